// ==== hdl/cafc_pkg.sv ====
// Package for the code address and fetch configuration block
package cafc_pkg;
	localparam logic [11:0] CAFC_OFF_SEG = 12'h000;
	localparam logic [11:0] CAFC_OFF_CFG = 12'h004;
	localparam logic [11:0] CAFC_OFF_VSEG = 12'h008;
	localparam logic [11:0] CAFC_OFF_STAT = 12'h00c;
	localparam int CAFC_ZERO_JUMP_BIT = 0;
	localparam int CAFC_BRANCH_PRED_BIT = 1;
	localparam int CAFC_CSI_BIT = 2;
	localparam int CAFC_SEGOFF_BIT = 3;
	localparam int CAFC_WDT_BIT = 4;
	localparam int CAFC_VSC_LO = 5;
	localparam logic [15:0] CAFC_CFG_MASK = 16'h007f;
	localparam logic [15:0] CAFC_CFG_RST = 16'h0000;
	localparam logic [7:0] CAFC_VSEG_RST = 8'h00;
	localparam logic [15:0] CAFC_OFFSET_RST = 16'h0000;
	localparam logic [4:0] CAFC_STRIDE_BASE = 5'h02;

	typedef enum logic [2:0] {
		CAFC_OP_NONE,
		CAFC_OP_FAR_JUMP,
		CAFC_OP_FAR_CALL,
		CAFC_OP_FAR_RET,
		CAFC_OP_INT_RET,
		CAFC_OP_VECTOR
	} cafc_seg_op_t;

	typedef struct packed {
		cafc_seg_op_t op;
		logic [7:0] seg;
		logic [15:0] offset;
		logic load_offset;
		logic step;
	} cafc_flow_t;

	typedef struct packed {
		logic wdt_disable;
		logic wdt_enable;
		logic end_init;
	} cafc_instr_t;
endpackage : cafc_pkg

// ==== hdl/cafc_top.sv ====
// Fetch address former with segment control and core configuration register
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Fetch address is segment byte above offset halfword, simply concatenated.
// - Space is 256 segments of 64 KB, 16 MB in all.
// - Offset is halfword aligned; bit 0 always zero.
// - Offset is not register mapped; changed only by flow events.
// - Only segment bits 7:0 used; bits 15:8 read zero.
// - Segment register is read only to bus writes.
// - Segment loads from the vector segment register on the first edge after reset release.
// - Config bit 3 disables segmentation; reset gives segmented mode.
// - Segmented: far jump, call, return and interrupt return set segment.
// - Interrupt or trap always loads segment from vector segment.
// - Non-segmented: far flow events leave the segment frozen.
// - Bits 6:5 scale vector spacing to 2, 4, 8 or 16 words.
// - Watchdog bit 0: disable only before end of init; 1: both always.
// - Blocked watchdog instructions execute as no-operation.
// - Bit 2 set makes the context switch interruptible.
// - Bit 1 enables branch prediction.
// - Bit 0 enables zero-cycle jump.
// - Config writes accepted only before end of init.
module cafc_top (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire cafc_pkg::cafc_flow_t flow, // Instruction flow events
	input wire cafc_pkg::cafc_instr_t instr, // Special instruction strobes
	output logic [23:0] fetch_addr, // Physical fetch address
	output logic [4:0] vector_stride, // Words between vectors
	output logic wdt_disable_exec, // Watchdog disable takes effect
	output logic wdt_enable_exec, // Watchdog enable takes effect
	output logic context_switch_interruptible, // Context switch interruptible
	output logic branch_predict_enable, // Branch prediction on
	output logic zero_cycle_jump_enable, // Zero-cycle jump on
	output logic supervisor // Still before end of init
);
	import cafc_pkg::*;

	logic [7:0] code_segment_reg;
	logic [15:0] fetch_offset_ptr;
	logic [15:0] core_config_one;
	logic [7:0] vector_segment_reg;
	logic seg_loaded;
	logic [7:0] next_seg;
	logic [15:0] next_offset;

	wire segmentation_off = core_config_one[CAFC_SEGOFF_BIT];
	wire watchdog_instr_cfg = core_config_one[CAFC_WDT_BIT];
	wire [1:0] vector_spacing = core_config_one[CAFC_VSC_LO +: 2];
	wire far_op = (flow.op == CAFC_OP_FAR_JUMP) || (flow.op == CAFC_OP_FAR_CALL) ||
		(flow.op == CAFC_OP_FAR_RET) || (flow.op == CAFC_OP_INT_RET);
	wire vec_op = (flow.op == CAFC_OP_VECTOR);
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_seg = (paddr == CAFC_OFF_SEG);
	wire hit_cfg = (paddr == CAFC_OFF_CFG);
	wire hit_vseg = (paddr == CAFC_OFF_VSEG);
	wire hit_stat = (paddr == CAFC_OFF_STAT);
	wire mapped = hit_seg || hit_cfg || hit_vseg || hit_stat;
	wire bad = !mapped || (pwrite && (hit_seg || hit_stat));
	wire wr_cfg = access && pwrite && hit_cfg && supervisor;
	wire wr_vseg = access && pwrite && hit_vseg;
	wire [31:0] rd_word = hit_seg ? {24'h000000, code_segment_reg} :
		hit_cfg ? {16'h0000, core_config_one} :
		hit_vseg ? {24'h000000, vector_segment_reg} :
		hit_stat ? {31'h00000000, supervisor} : 32'h00000000;
	wire [4:0] next_stride = CAFC_STRIDE_BASE << vector_spacing;
	wire wd_allowed = watchdog_instr_cfg || supervisor;

	// Far flow only moves the segment in segmented mode; vectors always do
	always_comb begin
		next_seg = code_segment_reg;
		if (!seg_loaded) begin
			next_seg = vector_segment_reg;
		end else if (vec_op) begin
			next_seg = vector_segment_reg;
		end else if (far_op && !segmentation_off) begin
			next_seg = flow.seg;
		end
	end

	// Offset has no bus path; low bit forced clear
	always_comb begin
		next_offset = fetch_offset_ptr;
		if (flow.load_offset) begin
			next_offset = {flow.offset[15:1], 1'b0};
		end else if (flow.step) begin
			next_offset = fetch_offset_ptr + 16'h0002;
		end
	end

	// Segment is taken from the vector register one edge after release, since
	// an async reset may only load constants
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_loaded <= 1'b0;
			code_segment_reg <= CAFC_VSEG_RST;
			fetch_offset_ptr <= CAFC_OFFSET_RST;
		end else begin
			seg_loaded <= 1'b1;
			code_segment_reg <= next_seg;
			fetch_offset_ptr <= next_offset;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_config_one <= CAFC_CFG_RST;
			vector_segment_reg <= CAFC_VSEG_RST;
			supervisor <= 1'b1;
		end else begin
			if (wr_cfg) begin
				core_config_one <= pwdata[15:0] & CAFC_CFG_MASK;
			end
			if (wr_vseg) begin
				vector_segment_reg <= pwdata[7:0];
			end
			if (instr.end_init) begin
				supervisor <= 1'b0;
			end
		end
	end

	// Zero-wait APB slave: ready comes one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && bad;
			prdata <= (setup && !pwrite) ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_addr <= {CAFC_VSEG_RST, CAFC_OFFSET_RST};
			vector_stride <= CAFC_STRIDE_BASE;
			wdt_disable_exec <= 1'b0;
			wdt_enable_exec <= 1'b0;
			context_switch_interruptible <= 1'b0;
			branch_predict_enable <= 1'b0;
			zero_cycle_jump_enable <= 1'b0;
		end else begin
			fetch_addr <= {next_seg, next_offset};
			vector_stride <= next_stride;
			wdt_disable_exec <= instr.wdt_disable && wd_allowed;
			wdt_enable_exec <= instr.wdt_enable && watchdog_instr_cfg;
			context_switch_interruptible <= core_config_one[CAFC_CSI_BIT];
			branch_predict_enable <= core_config_one[CAFC_BRANCH_PRED_BIT];
			zero_cycle_jump_enable <= core_config_one[CAFC_ZERO_JUMP_BIT];
		end
	end

	property p_addr_concat;
		@(posedge pclk) disable iff (!presetn)
		##1 fetch_addr == {code_segment_reg, fetch_offset_ptr};
	endproperty
	a_addr_concat: assert property (p_addr_concat) else $error("fetch address not concatenated");

	property p_align;
		@(posedge pclk) disable iff (!presetn) fetch_offset_ptr[0] == 1'b0;
	endproperty
	a_align: assert property (p_align) else $error("fetch offset misaligned");

	property p_frozen;
		@(posedge pclk) disable iff (!presetn)
		seg_loaded && segmentation_off && far_op |=> $stable(code_segment_reg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("segment moved while unsegmented");

	property p_far;
		@(posedge pclk) disable iff (!presetn)
		seg_loaded && !segmentation_off && far_op |=> code_segment_reg == $past(flow.seg);
	endproperty
	a_far: assert property (p_far) else $error("far flow did not set segment");

	property p_vec;
		@(posedge pclk) disable iff (!presetn)
		vec_op |=> code_segment_reg == $past(vector_segment_reg);
	endproperty
	a_vec: assert property (p_vec) else $error("vector did not load segment");

	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		!supervisor |=> $stable(core_config_one);
	endproperty
	a_lock: assert property (p_lock) else $error("config changed after end of init");

	property p_rsvd;
		@(posedge pclk) disable iff (!presetn) core_config_one[15:7] == 9'h000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved config bits set");

	property p_stride;
		@(posedge pclk) disable iff (!presetn)
		##1 vector_stride == (5'h02 << $past(vector_spacing));
	endproperty
	a_stride: assert property (p_stride) else $error("vector stride wrong");

	property p_wdt_nop;
		@(posedge pclk) disable iff (!presetn)
		!supervisor && !watchdog_instr_cfg |=> !wdt_disable_exec && !wdt_enable_exec;
	endproperty
	a_wdt_nop: assert property (p_wdt_nop) else $error("watchdog instruction not blocked");

	sequence s_seg_write;
		access && pwrite && hit_seg;
	endsequence
	property p_ro;
		@(posedge pclk) disable iff (!presetn)
		(s_seg_write and (seg_loaded && !vec_op && !far_op)) |=> $stable(code_segment_reg);
	endproperty
	a_ro: assert property (p_ro) else $error("bus write changed segment");

	// Bus phases as named steps, so the register checks read like the transfer
	sequence s_bus_setup;
		setup;
	endsequence

	sequence s_bus_read_seg;
		setup && !pwrite && hit_seg;
	endsequence

	sequence s_cfg_commit;
		access && pwrite && hit_cfg;
	endsequence

	sequence s_vec_event;
		vec_op;
	endsequence

	property p_ready_follows;
		@(posedge pclk) disable iff (!presetn)
		s_bus_setup |=> pready;
	endproperty
	a_ready_follows: assert property (p_ready_follows) else $error("ready missing after setup");

	property p_seg_read_upper;
		@(posedge pclk) disable iff (!presetn)
		s_bus_read_seg |=> prdata[31:8] == 24'h000000;
	endproperty
	a_seg_read_upper: assert property (p_seg_read_upper) else $error("segment upper bits not zero");

	property p_seg_write_err;
		@(posedge pclk) disable iff (!presetn)
		setup && pwrite && hit_seg |=> pslverr;
	endproperty
	a_seg_write_err: assert property (p_seg_write_err) else $error("segment write not refused");

	property p_cfg_write;
		@(posedge pclk) disable iff (!presetn)
		(s_cfg_commit and supervisor) |=> core_config_one == ($past(pwdata[15:0]) & CAFC_CFG_MASK);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not taken");

	property p_cfg_locked;
		@(posedge pclk) disable iff (!presetn)
		(s_cfg_commit and (!supervisor)) |=> $stable(core_config_one);
	endproperty
	a_cfg_locked: assert property (p_cfg_locked) else $error("late config write took effect");

	property p_seg_first_load;
		@(posedge pclk) disable iff (!presetn)
		!seg_loaded |=> code_segment_reg == $past(vector_segment_reg);
	endproperty
	a_seg_first_load: assert property (p_seg_first_load) else $error("segment not loaded at reset");

	property p_seg_idle;
		@(posedge pclk) disable iff (!presetn)
		seg_loaded && (flow.op == CAFC_OP_NONE) |=> $stable(code_segment_reg);
	endproperty
	a_seg_idle: assert property (p_seg_idle) else $error("segment moved without flow event");

	property p_vec_any_mode;
		@(posedge pclk) disable iff (!presetn)
		(s_vec_event ##0 segmentation_off) |=> code_segment_reg == $past(vector_segment_reg);
	endproperty
	a_vec_any_mode: assert property (p_vec_any_mode) else $error("vector ignored when unsegmented");

	property p_offset_load;
		@(posedge pclk) disable iff (!presetn)
		flow.load_offset |=> fetch_offset_ptr == {$past(flow.offset[15:1]), 1'b0};
	endproperty
	a_offset_load: assert property (p_offset_load) else $error("offset load wrong");

	property p_offset_step;
		@(posedge pclk) disable iff (!presetn)
		flow.step && !flow.load_offset |=> fetch_offset_ptr == $past(fetch_offset_ptr) + 16'h0002;
	endproperty
	a_offset_step: assert property (p_offset_step) else $error("offset step wrong");

	property p_offset_hold;
		@(posedge pclk) disable iff (!presetn)
		!flow.load_offset && !flow.step |=> $stable(fetch_offset_ptr);
	endproperty
	a_offset_hold: assert property (p_offset_hold) else $error("offset moved without flow event");

	property p_csi_copy;
		@(posedge pclk) disable iff (!presetn)
		##1 context_switch_interruptible == $past(core_config_one[CAFC_CSI_BIT]);
	endproperty
	a_csi_copy: assert property (p_csi_copy) else $error("context switch bit not mirrored");

	property p_bpred_copy;
		@(posedge pclk) disable iff (!presetn)
		##1 branch_predict_enable == $past(core_config_one[CAFC_BRANCH_PRED_BIT]);
	endproperty
	a_bpred_copy: assert property (p_bpred_copy) else $error("branch prediction bit not mirrored");

	property p_zjump_copy;
		@(posedge pclk) disable iff (!presetn)
		##1 zero_cycle_jump_enable == $past(core_config_one[CAFC_ZERO_JUMP_BIT]);
	endproperty
	a_zjump_copy: assert property (p_zjump_copy) else $error("zero jump bit not mirrored");

	property p_end_init;
		@(posedge pclk) disable iff (!presetn)
		instr.end_init |=> !supervisor;
	endproperty
	a_end_init: assert property (p_end_init) else $error("end of init kept supervisor");

	property p_sup_sticky;
		@(posedge pclk) disable iff (!presetn)
		!supervisor |=> !supervisor;
	endproperty
	a_sup_sticky: assert property (p_sup_sticky) else $error("supervisor mode came back");

	property p_wdt_dis_ok;
		@(posedge pclk) disable iff (!presetn)
		instr.wdt_disable && wd_allowed |=> wdt_disable_exec;
	endproperty
	a_wdt_dis_ok: assert property (p_wdt_dis_ok) else $error("allowed watchdog disable lost");

	property p_wdt_en_ok;
		@(posedge pclk) disable iff (!presetn)
		instr.wdt_enable && watchdog_instr_cfg |=> wdt_enable_exec;
	endproperty
	a_wdt_en_ok: assert property (p_wdt_en_ok) else $error("allowed watchdog enable lost");
endmodule : cafc_top
`default_nettype wire

// ==== testbench/test_cafc_top.sv ====
// Self-checking bench for the code address and fetch configuration block
`timescale 1ns/1ps
`default_nettype none
module test_cafc_top;
	import cafc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic wde, wee, csi, bpe, zje, sup;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] fetch_addr;
	logic [4:0] vector_stride;
	cafc_flow_t flow;
	cafc_instr_t instr;
	int errors = 0;
	int check_count = 0;
	// Reserved upper config bits are set in the first row on purpose
	logic [31:0] row_w [4] = '{32'hffff_ff00, 32'h0000_0027, 32'h0000_0043, 32'h0000_0064};
	logic [31:0] row_s [4] = '{32'h2, 32'h4, 32'h8, 32'h10};
	cafc_top i_cafc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flow(flow),
		.instr(instr), .fetch_addr(fetch_addr), .vector_stride(vector_stride), .wdt_disable_exec(wde),
		.wdt_enable_exec(wee), .context_switch_interruptible(csi), .branch_predict_enable(bpe),
		.zero_cycle_jump_enable(zje), .supervisor(sup));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	// Waits for pready with no bound of its own; only the watchdog ends a missing answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		chk("ready wait", 32'(n), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic fl(input cafc_seg_op_t op, input logic [7:0] s, input logic [15:0] o);
		@(posedge pclk);
		flow <= '{op: op, seg: s, offset: o, load_offset: 1'b1, step: 1'b0};
		@(posedge pclk);
		flow <= '0;
		#1;
	endtask : fl
	task automatic pulse(input logic [2:0] i);
		@(posedge pclk);
		instr <= cafc_instr_t'(i);
		@(posedge pclk);
		instr <= '0;
		#1;
	endtask : pulse
	task final_report;
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		flow = '0;
		instr = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk("stride rst", 32'(vector_stride), 32'h2);
		chk("sup rst", 32'(sup), 32'h1);
		chk("fetch rst", 32'(fetch_addr), 32'h0);
		apb(1'b0, CAFC_OFF_CFG, 32'h0);
		chk("cfg rst", rd, 32'h0);
		apb(1'b0, CAFC_OFF_STAT, 32'h0);
		chk("stat rst", rd, 32'h1);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, CAFC_OFF_CFG, row_w[k]);
			apb(1'b0, CAFC_OFF_CFG, 32'h0);
			chk("cfg", rd, row_w[k] & 32'h7f);
			chk("stride", 32'(vector_stride), row_s[k]);
			chk("cfg bits", 32'({csi, bpe, zje}), 32'(row_w[k][2:0]));
		end
		apb(1'b1, CAFC_OFF_VSEG, 32'h12);
		// Odd offsets prove bit 0 is dropped
		for (int k = 1; k < 5; k++) begin
			fl(cafc_seg_op_t'(k), 8'(8'h30 + k), 16'(16'h1000 * k + 1));
			chk("far op", 32'(fetch_addr), 32'({8'(8'h30 + k), 16'(16'h1000 * k)}));
		end
		fl(CAFC_OP_VECTOR, 8'hee, 16'h0100);
		chk("vector", 32'(fetch_addr), 32'h120100);
		apb(1'b1, CAFC_OFF_SEG, 32'h55);
		chk("seg wr err", 32'(er), 32'h1);
		apb(1'b0, CAFC_OFF_SEG, 32'h0);
		chk("seg rd", rd, 32'h12);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
		apb(1'b1, CAFC_OFF_CFG, 32'h08);
		fl(CAFC_OP_FAR_JUMP, 8'h77, 16'h2000);
		chk("frozen jump", 32'(fetch_addr), 32'h122000);
		fl(CAFC_OP_INT_RET, 8'h78, 16'h3000);
		chk("frozen", 32'(fetch_addr), 32'h123000);
		@(posedge pclk);
		flow <= '{op: CAFC_OP_NONE, seg: 8'hff, offset: 16'h0000, load_offset: 1'b0, step: 1'b1};
		@(posedge pclk);
		flow <= '0;
		#1;
		chk("step", 32'(fetch_addr), 32'h123002);
		apb(1'b1, CAFC_OFF_VSEG, 32'h12);
		fl(CAFC_OP_VECTOR, 8'h00, 16'h0040);
		chk("vector ns", 32'(fetch_addr), 32'h120040);
		pulse(3'b100);
		chk("wdt dis", 32'(wde), 32'h1);
		pulse(3'b010);
		chk("wdt en off", 32'(wee), 32'h0);
		apb(1'b1, CAFC_OFF_CFG, 32'h10);
		pulse(3'b010);
		chk("wdt en on", 32'(wee), 32'h1);
		apb(1'b1, CAFC_OFF_CFG, 32'h0);
		pulse(3'b001);
		chk("sup end", 32'(sup), 32'h0);
		pulse(3'b100);
		chk("wdt dis late", 32'(wde), 32'h0);
		apb(1'b0, CAFC_OFF_STAT, 32'h0);
		chk("stat end", rd, 32'h0);
		apb(1'b1, CAFC_OFF_CFG, 32'h1f);
		apb(1'b0, CAFC_OFF_CFG, 32'h0);
		chk("cfg locked", {rd[30:0], er}, 32'h0);
		// Mid-run reset must restore supervisor mode and reopen the config register
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk("sup rerst", 32'(sup), 32'h1);
		chk("fetch rerst", 32'(fetch_addr), 32'h0);
		apb(1'b1, CAFC_OFF_CFG, 32'h01);
		apb(1'b0, CAFC_OFF_CFG, 32'h0);
		chk("cfg reopen", rd, 32'h1);
		chk("zero jump", 32'(zje), 32'h1);
		final_report();
	end
endmodule : test_cafc_top
`default_nettype wire
